// ---- rtl/ccs_pkg.sv ----
package ccs_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int          REG_W             = 16;
	localparam int          ADDR_W            = 16;
	localparam logic [15:0] RATE_SEL_ADDR     = 16'he220;
	localparam logic [15:0] CLK_EN_ADDR       = 16'he280;
	localparam logic [4:0]  RATE_SEL_RST      = 5'h00;
	localparam logic [8:0]  CLK_EN_RST        = 9'h000;
	localparam int          SEL_W             = 5;
	localparam int          EN_W              = 9;

	// ---------------------------------------------------------------
	// Start pulse select codes
	// ---------------------------------------------------------------
	localparam logic [4:0]  SEL_NORMAL        = 5'h00;
	localparam logic [4:0]  SEL_DUAL          = 5'h01;
	localparam logic [4:0]  SEL_QUAD          = 5'h02;
	localparam logic [4:0]  SEL_SIN_BASE      = 5'h03;
	localparam logic [4:0]  SEL_SOUT_BASE     = 5'h0f;
	localparam logic [4:0]  SEL_SPDIF         = 5'h1b;
	localparam logic [4:0]  SEL_OFF_BASE      = 5'h1c;
	localparam int          PAIRS             = 12;

	// ---------------------------------------------------------------
	// Subsystem clock enable bit positions
	// ---------------------------------------------------------------
	localparam int          EN_ROUTING        = 0;
	localparam int          EN_SER_IN         = 1;
	localparam int          EN_SER_OUT        = 2;
	localparam int          EN_RATE_CONV_LO   = 3;
	localparam int          EN_RATE_CONV_HI   = 4;
	localparam int          EN_CORE           = 5;
	localparam int          EN_SPDIF_RX       = 6;
	localparam int          EN_SPDIF_TX       = 7;
	localparam int          EN_AUX_CONV       = 8;

	// ---------------------------------------------------------------
	// Rate figures
	// ---------------------------------------------------------------
	localparam int          CORE_MULT         = 56;
	localparam int          CLKOUT256_MULT    = 8;
	localparam int          CLKOUT512_MULT    = 16;
	localparam logic [5:0]  REF_MASK_NORMAL   = 6'h3f;
	localparam logic [5:0]  REF_MASK_DUAL     = 6'h1f;
	localparam logic [5:0]  REF_MASK_QUAD     = 6'h0f;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		CCS_CO_OFF = 2'h0,
		CCS_CO_OSC = 2'h1,
		CCS_CO_256 = 2'h2,
		CCS_CO_512 = 2'h3
	} ccs_clock_output_pin_mode_t;

	typedef enum logic [1:0] {
		CCS_ST_WAIT0 = 2'h0,
		CCS_ST_WAIT1 = 2'h1,
		CCS_ST_CAPT  = 2'h3,
		CCS_ST_RUN   = 2'h2
	} ccs_state_t;

	// Input divider ratio from the strap code, zero when unsupported
	function automatic logic [3:0] ccs_div_ratio(input logic [2:0] code);
		case (code)
			3'h0:    ccs_div_ratio = 4'h1;
			3'h1:    ccs_div_ratio = 4'h2;
			3'h2:    ccs_div_ratio = 4'h4;
			3'h3:    ccs_div_ratio = 4'h6;
			3'h4:    ccs_div_ratio = 4'h8;
			default: ccs_div_ratio = 4'h0;
		endcase
	endfunction

endpackage

// ---- rtl/ccs_rate_mult.sv ----
`timescale 1ns/100ps
// Digital rate multiplier: emits up to MULT evenly spread ticks per
// reference period, using the period measured over the last one.
module ccs_rate_mult #(
	parameter int MULT  = 56,
	parameter int CNT_W = 12
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// Reference and output
	input  wire logic ref_tick,
	output logic      tick_q
);
	localparam logic [CNT_W:0] MULT_C = (CNT_W+1)'(MULT);

	logic [CNT_W-1:0] per_cnt_q;
	logic [CNT_W-1:0] period_q;
	logic [CNT_W:0]   acc_q;
	logic [CNT_W:0]   acc_base;
	logic [CNT_W:0]   acc_n;
	logic [7:0]       ticks_q;
	logic [7:0]       ticks_base;

	// A reference tick opens a new period that already counts this cycle,
	// otherwise every period loses one share and falls a tick short
	assign acc_base   = ref_tick ? '0 : acc_q;
	assign ticks_base = ref_tick ? 8'h00 : ticks_q;
	assign acc_n      = acc_base + MULT_C;

	// Period measurement, saturating when the reference stops
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n) begin
			per_cnt_q <= '0;
			period_q  <= '0;
		end else if (clk_en) begin
			if (ref_tick) begin
				per_cnt_q <= '0;
				period_q  <= per_cnt_q + 1'b1;
			end else if (per_cnt_q != '1) begin
				per_cnt_q <= per_cnt_q + 1'b1;
			end
		end
	end

	// Accumulator spreading ticks, capped at MULT per period
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n) begin
			acc_q   <= '0;
			ticks_q <= '0;
			tick_q  <= 1'b0;
		end else if (clk_en) begin
			tick_q  <= 1'b0;
			acc_q   <= acc_base;
			ticks_q <= ticks_base;
			if (period_q != '0 && 8'(MULT) > ticks_base) begin
				if (acc_n >= {1'b0, period_q}) begin
					acc_q   <= acc_n - {1'b0, period_q};
					ticks_q <= ticks_base + 8'h01;
					tick_q  <= 1'b1;
				end else begin
					acc_q <= acc_n;
				end
			end
		end
	end

endmodule

// ---- rtl/ccs_core_clock_ctrl.sv ----
`timescale 1ns/100ps
module ccs_core_clock_ctrl
	import ccs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic                   clk_en,
	// Strap pins
	input  wire logic                   divider_select_bit0,
	input  wire logic                   divider_select_bit1,
	input  wire logic                   divider_select_bit2,
	input  wire logic                   clock_output_mode_bit0,
	input  wire logic                   clock_output_mode_bit1,
	// Clock and frame inputs
	input  wire logic                   crystal_input,
	input  wire logic [ccs_pkg::PAIRS-1:0] serial_in_frame_clk,
	input  wire logic [ccs_pkg::PAIRS-1:0] serial_out_frame_clk,
	input  wire logic                   spdif_frame_clk,
	// Register port
	input  wire logic                   reg_wr_en,
	input  wire logic                   reg_rd_en,
	input  wire logic [ccs_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ccs_pkg::REG_W-1:0]  reg_wdata,
	output logic [ccs_pkg::REG_W-1:0]       reg_rdata_q,
	output logic                        reg_rd_valid_q,
	// Clock outputs
	output logic                        clock_output_pin_q,
	output logic                        clock_output_oe_q,
	output logic                        core_clock_tick_q,
	output logic                        core_start_pulse_q,
	output logic [ccs_pkg::EN_W-1:0]    subsystem_mclk_q,
	output logic [ccs_pkg::EN_W-1:0]    subsystem_clk_en_q
);
	import ccs_pkg::*;

	localparam int SYN_W = 2*PAIRS + 7;

	logic             rst_meta_q;
	logic             rst_n_s;
	logic [SYN_W-1:0] pins;
	logic [SYN_W-1:0] meta_q;
	logic [SYN_W-1:0] sync_q;
	logic [SYN_W-1:0] prev_q;
	logic             xtal_s;
	logic             xtal_rise;
	logic [PAIRS-1:0] sin_rise;
	logic [PAIRS-1:0] sout_rise;
	logic             spdif_rise;
	ccs_state_t       state_q;
	logic [2:0]       div_code_q;
	ccs_clock_output_pin_mode_t mode_q;
	logic [3:0]       ratio;
	logic [3:0]       edge_cnt_q;
	logic             ref_tick_q;
	logic [5:0]       ref_cnt_q;
	logic             norm_pulse;
	logic             dual_pulse;
	logic             quad_pulse;
	logic [SEL_W-1:0] rate_sel_q;
	logic [EN_W-1:0]  clk_en_reg_q;
	logic             start_d;
	logic [4:0]       sin_idx;
	logic [4:0]       sout_idx;
	logic             tick256;
	logic             tick512;
	logic             tog256_q;
	logic             tog512_q;
	logic [6:0]       core_cnt_q;

	// ---------------------------------------------------------------
	// Reset release and pin synchronisers
	// ---------------------------------------------------------------
	// Reset released through two flops
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_n_s    <= 1'b0;
		end else if (clk_en) begin
			rst_meta_q <= 1'b1;
			rst_n_s    <= rst_meta_q;
		end
	end

	assign pins = {spdif_frame_clk, serial_out_frame_clk,
		serial_in_frame_clk, clock_output_mode_bit1,
		clock_output_mode_bit0, divider_select_bit2,
		divider_select_bit1, divider_select_bit0, crystal_input};

	// Two-flop synchroniser plus a delayed copy for edges
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else if (clk_en) begin
			meta_q <= pins;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign xtal_s     = sync_q[0];
	assign xtal_rise  = sync_q[0] & ~prev_q[0];
	assign sin_rise   = sync_q[6 +: PAIRS] & ~prev_q[6 +: PAIRS];
	assign sout_rise  = sync_q[6+PAIRS +: PAIRS] & ~prev_q[6+PAIRS +: PAIRS];
	assign spdif_rise = sync_q[SYN_W-1] & ~prev_q[SYN_W-1];

	// ---------------------------------------------------------------
	// Strap capture after reset release
	// ---------------------------------------------------------------
	// Straps are read once, after the synchronisers have filled
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s) begin
			state_q    <= CCS_ST_WAIT0;
			div_code_q <= 3'h0;
			mode_q     <= CCS_CO_OFF;
		end else if (clk_en) begin
			case (state_q)
				CCS_ST_WAIT0: state_q <= CCS_ST_WAIT1;
				CCS_ST_WAIT1: state_q <= CCS_ST_CAPT;
				CCS_ST_CAPT:
				begin
					div_code_q <= sync_q[3:1];
					mode_q     <= ccs_clock_output_pin_mode_t'(sync_q[5:4]);
					state_q    <= CCS_ST_RUN;
				end
				CCS_ST_RUN:   state_q <= CCS_ST_RUN;
				default:      state_q <= CCS_ST_WAIT0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Input divider and internal rate pulses
	// ---------------------------------------------------------------
	assign ratio = ccs_div_ratio(div_code_q);

	// Divide crystal rising edges down to the 64x reference
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s) begin
			edge_cnt_q <= 4'h0;
			ref_tick_q <= 1'b0;
		end else if (clk_en) begin
			ref_tick_q <= 1'b0;
			if (state_q == CCS_ST_RUN && xtal_rise && ratio != 4'h0) begin
				if (edge_cnt_q >= ratio - 4'h1) begin
					edge_cnt_q <= 4'h0;
					ref_tick_q <= 1'b1;
				end else begin
					edge_cnt_q <= edge_cnt_q + 4'h1;
				end
			end
		end
	end

	// Reference ticks counted per normal sample
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			ref_cnt_q <= 6'h00;
		else if (clk_en && ref_tick_q)
			ref_cnt_q <= ref_cnt_q + 6'h01;
	end

	assign norm_pulse = ref_tick_q && (ref_cnt_q & REF_MASK_NORMAL) ==
		REF_MASK_NORMAL;
	assign dual_pulse = ref_tick_q && (ref_cnt_q & REF_MASK_DUAL) ==
		REF_MASK_DUAL;
	assign quad_pulse = ref_tick_q && (ref_cnt_q & REF_MASK_QUAD) ==
		REF_MASK_QUAD;

	// Core tick and clock output rate multipliers
	ccs_rate_mult #(.MULT(CORE_MULT)) u_core_mult (
		.core_clk (core_clk),
		.rst_n    (rst_n_s),
		.clk_en   (clk_en),
		.ref_tick (ref_tick_q),
		.tick_q   (core_clock_tick_q)
	);

	ccs_rate_mult #(.MULT(CLKOUT256_MULT)) u_out256_mult (
		.core_clk (core_clk),
		.rst_n    (rst_n_s),
		.clk_en   (clk_en),
		.ref_tick (ref_tick_q),
		.tick_q   (tick256)
	);

	ccs_rate_mult #(.MULT(CLKOUT512_MULT)) u_out512_mult (
		.core_clk (core_clk),
		.rst_n    (rst_n_s),
		.clk_en   (clk_en),
		.ref_tick (ref_tick_q),
		.tick_q   (tick512)
	);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Writes keep only the defined field bits
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s) begin
			rate_sel_q   <= RATE_SEL_RST;
			clk_en_reg_q <= CLK_EN_RST;
		end else if (clk_en && reg_wr_en) begin
			if (reg_addr == RATE_SEL_ADDR)
				rate_sel_q <= reg_wdata[SEL_W-1:0];
			if (reg_addr == CLK_EN_ADDR)
				clk_en_reg_q <= reg_wdata[EN_W-1:0];
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s) begin
			reg_rdata_q    <= '0;
			reg_rd_valid_q <= 1'b0;
		end else if (clk_en) begin
			reg_rd_valid_q <= reg_rd_en;
			reg_rdata_q    <= '0;
			if (reg_rd_en && reg_addr == RATE_SEL_ADDR)
				reg_rdata_q <= {{(REG_W-SEL_W){1'b0}}, rate_sel_q};
			else if (reg_rd_en && reg_addr == CLK_EN_ADDR)
				reg_rdata_q <= {{(REG_W-EN_W){1'b0}}, clk_en_reg_q};
		end
	end

	// ---------------------------------------------------------------
	// Start pulse selection
	// ---------------------------------------------------------------
	assign sin_idx  = rate_sel_q - SEL_SIN_BASE;
	assign sout_idx = rate_sel_q - SEL_SOUT_BASE;

	// Pick the source of the core start pulse
	always_comb
	begin
		start_d = 1'b0;
		if (rate_sel_q == SEL_NORMAL)
			start_d = norm_pulse;
		else if (rate_sel_q == SEL_DUAL)
			start_d = dual_pulse;
		else if (rate_sel_q == SEL_QUAD)
			start_d = quad_pulse;
		else if (rate_sel_q < SEL_SOUT_BASE)
			start_d = sin_rise[sin_idx[3:0]];
		else if (rate_sel_q < SEL_SPDIF)
			start_d = sout_rise[sout_idx[3:0]];
		else if (rate_sel_q == SEL_SPDIF)
			start_d = spdif_rise;
		else
			start_d = 1'b0;
	end

	// Registered start pulse to the core
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			core_start_pulse_q <= 1'b0;
		else if (clk_en)
			core_start_pulse_q <= start_d;
	end

	// ---------------------------------------------------------------
	// Subsystem clock gating and clock output
	// ---------------------------------------------------------------
	// Enables move only while the master clock is low
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s) begin
			subsystem_clk_en_q <= '0;
			subsystem_mclk_q   <= '0;
		end else if (clk_en) begin
			if (!xtal_s)
				subsystem_clk_en_q <= clk_en_reg_q;
			subsystem_mclk_q <= {EN_W{xtal_s}} & subsystem_clk_en_q;
		end
	end

	// Clock output source per mode strap
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s) begin
			tog256_q           <= 1'b0;
			tog512_q           <= 1'b0;
			clock_output_pin_q <= 1'b0;
			clock_output_oe_q  <= 1'b0;
		end else if (clk_en) begin
			tog256_q          <= tog256_q ^ tick256;
			tog512_q          <= tog512_q ^ tick512;
			clock_output_oe_q <= (mode_q != CCS_CO_OFF);
			case (mode_q)
				CCS_CO_OSC: clock_output_pin_q <= xtal_s;
				CCS_CO_256: clock_output_pin_q <= tog256_q;
				CCS_CO_512: clock_output_pin_q <= tog512_q;
				default:    clock_output_pin_q <= 1'b0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	// Core ticks seen since the last reference tick
	always_ff @(posedge core_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			core_cnt_q <= 7'h00;
		else if (clk_en && ref_tick_q)
			core_cnt_q <= 7'h00;
		else if (clk_en && core_clock_tick_q)
			core_cnt_q <= core_cnt_q + 7'h01;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n_s || !clk_en);

	a_div_ratio: assert property (ref_tick_q |-> $past(xtal_rise) &&
		$past(edge_cnt_q) == ratio - 4'h1)
		else $error("reference tick off the divide ratio");
	a_core_mult: assert property (ref_tick_q |-> core_cnt_q <= 7'd56)
		else $error("more than 56 core ticks per reference");
	a_start_internal: assert property ((rate_sel_q == 5'h00) &&
		norm_pulse |=> core_start_pulse_q)
		else $error("normal start pulse missing");
	a_start_serin: assert property ((rate_sel_q == 5'h03) &&
		sin_rise[0] |=> core_start_pulse_q)
		else $error("serial input start pulse missing");
	a_start_serout: assert property ((rate_sel_q == 5'h1a) &&
		sout_rise[11] |=> core_start_pulse_q)
		else $error("serial output start pulse missing");
	a_start_spdif: assert property ((rate_sel_q == 5'h1b) &&
		spdif_rise |=> core_start_pulse_q)
		else $error("receiver start pulse missing");
	a_start_off: assert property (rate_sel_q >= 5'h1c |=>
		!core_start_pulse_q)
		else $error("start pulse while core disabled");
	a_clock_output_pin_off: assert property (mode_q == CCS_CO_OFF |=>
		!clock_output_oe_q && !clock_output_pin_q)
		else $error("clock output driven while off");
	a_clock_output_pin_osc: assert property (mode_q == CCS_CO_OSC |=>
		clock_output_pin_q == $past(xtal_s))
		else $error("clock output not following oscillator");
	a_reserved_zero: assert property (reg_rd_valid_q |->
		reg_rdata_q[15:9] == 7'h00)
		else $error("reserved bits read nonzero");
	a_enable_write: assert property (reg_wr_en &&
		reg_addr == CLK_EN_ADDR |=> clk_en_reg_q == $past(reg_wdata[8:0]))
		else $error("enable register not written");
	a_gate_lowphase: assert property ($changed(subsystem_clk_en_q) |->
		!$past(xtal_s))
		else $error("gate changed during clock high");

	c_start_serin: cover property (rate_sel_q == 5'h05 && core_start_pulse_q);
	c_start_dual: cover property (rate_sel_q == 5'h01 && core_start_pulse_q);
	c_clock_output_pin_512: cover property (mode_q == CCS_CO_512 && clock_output_pin_q);
	c_gate_on: cover property (subsystem_mclk_q[EN_CORE]);

endmodule

// ---- tb/ccs_clock_source.sv ----
`timescale 1ns/100ps
// Crystal and frame clock source standing at the far side of the block
module ccs_clock_source (
	// Timing
	input  wire logic        core_clk,
	input  wire logic [7:0]  xtal_half,
	// Frame event request
	input  wire logic        frame_go,
	input  wire logic [4:0]  frame_idx,
	// Source outputs
	output logic             crystal_input,
	output logic [11:0]      serial_in_frame_clk,
	output logic [11:0]      serial_out_frame_clk,
	output logic             spdif_frame_clk
);
	logic [7:0]  ph_q = 8'h00;
	logic [24:0] fr_q = 25'h0;
	logic [3:0]  hold_q = 4'h0;
	logic        xt_q = 1'b0;

	// Crystal flips every xtal_half cycles, skewed off the core edge
	always @(posedge core_clk)
	begin
		ph_q <= (ph_q + 8'h01 >= xtal_half) ? 8'h00 : ph_q + 8'h01;
		if (ph_q + 8'h01 >= xtal_half && xtal_half != 8'h00)
			xt_q <= #1.7 ~xt_q;
	end

	// A request raises one frame clock for nine cycles; idle low
	always @(posedge core_clk)
	begin
		if (frame_go)
		begin
			fr_q <= #1.3 25'h1 << frame_idx;
			hold_q <= 4'h8;
		end
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
		else
			fr_q <= #1.3 25'h0;
	end

	// Output lines
	assign crystal_input = xt_q;
	assign serial_in_frame_clk = fr_q[11:0];
	assign serial_out_frame_clk = fr_q[23:12];
	assign spdif_frame_clk = fr_q[24];
endmodule

// ---- tb/ccs_core_clock_ctrl_test.sv ----
`timescale 1ns/100ps
module ccs_core_clock_ctrl_test;
	import ccs_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] d;
		logic [15:0] e;
	} ccs_row_t;
	ccs_row_t    rows [6] = '{
		'{16'he220, 16'hffff, 16'h001f},
		'{16'he280, 16'hfe00, 16'h0000},
		'{16'he280, 16'h0155, 16'h0155},
		'{16'he123, 16'hffff, 16'h0000},
		'{16'he220, 16'h001b, 16'h001b},
		'{16'he280, 16'h01ff, 16'h01ff}};
	int          div_exp [6] = '{64, 128, 256, 384, 512, 0};
	int          clk_exp [4] = '{0, 400, 400, 800};
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        clk_en = 1'b1;
	logic [2:0]  div_sel = 3'h0;
	logic [1:0]  mode_sel = 2'h0;
	logic [7:0]  xtal_half = 8'h02;
	logic        frame_go = 1'b0;
	logic [4:0]  frame_idx = 5'h00;
	logic        reg_wr_en = 1'b0;
	logic        reg_rd_en = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata_q, got;
	logic [11:0] serial_in_frame_clk, serial_out_frame_clk;
	logic        crystal_input, spdif_frame_clk, reg_rd_valid_q, prev;
	logic        clock_output_pin_q, clock_output_oe_q;
	logic        core_clock_tick_q, core_start_pulse_q;
	logic [8:0]  subsystem_mclk_q, subsystem_clk_en_q, acc;
	int          fails = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          iv, tk, n;

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	// Design and far-side source
	ccs_core_clock_ctrl i_ccs_core_clock_ctrl (.core_clk, .rst_b, .clk_en,
		.divider_select_bit0(div_sel[0]), .divider_select_bit1(div_sel[1]),
		.divider_select_bit2(div_sel[2]),
		.clock_output_mode_bit0(mode_sel[0]),
		.clock_output_mode_bit1(mode_sel[1]), .crystal_input,
		.serial_in_frame_clk, .serial_out_frame_clk, .spdif_frame_clk,
		.reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_q,
		.reg_rd_valid_q, .clock_output_pin_q, .clock_output_oe_q,
		.core_clock_tick_q, .core_start_pulse_q, .subsystem_mclk_q,
		.subsystem_clk_en_q);
	ccs_clock_source i_ccs_clock_source (.core_clk, .xtal_half, .frame_go,
		.frame_idx, .crystal_input, .serial_in_frame_clk,
		.serial_out_frame_clk, .spdif_frame_clk);

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic step(input int k = 1);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic near(input int g, input int e);
		chk(16'((g >= e - 2 && g <= e + 2) ? e : g), 16'(e));
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		step();
		reg_wr_en = 1'b0;
		step();
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		reg_addr = a;
		reg_rd_en = 1'b1;
		step();
		reg_rd_en = 1'b0;
		chk({15'h0, reg_rd_valid_q}, 16'h0001);
		d = reg_rdata_q;
		step();
	endtask

	// Straps move only under reset, enables are written first
	task automatic boot(input logic [2:0] dv, input logic [1:0] md,
		input logic [7:0] hf);
		rst_b = 1'b0;
		step();
		div_sel = dv;
		mode_sel = md;
		xtal_half = hf;
		step(6);
		rst_b = 1'b1;
		step(8);
		chk({7'h0, subsystem_clk_en_q}, 16'h0000);
		wr(CLK_EN_ADDR, 16'h01ff);
	endtask

	// Cycles and core ticks between two start pulses
	task automatic meas(output int v, output int t);
		int w;
		w = 0;
		v = 0;
		t = 0;
		while (core_start_pulse_q !== 1'b1 && w < 5000)
		begin
			step();
			w++;
		end
		if (w == 5000)
			return;
		do
		begin
			step();
			v++;
			t += int'(core_clock_tick_q === 1'b1);
		end while (core_start_pulse_q !== 1'b1 && v < 5000);
	endtask

	task automatic fire(input int idx, input logic [15:0] e);
		int p;
		p = 0;
		frame_idx = 5'(idx);
		frame_go = 1'b1;
		step();
		frame_go = 1'b0;
		repeat (12)
		begin
			step();
			p += int'(core_start_pulse_q === 1'b1);
		end
		chk(16'(p), e);
	endtask

	// Cycle ceiling cuts a hang short
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			fails++;
			stop_test();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		step(3);
		chk({5'h0, reg_rd_valid_q, core_start_pulse_q, subsystem_clk_en_q},
			16'h0000);
		boot(3'h2, 2'h1, 8'h02);
		rd(RATE_SEL_ADDR, got);
		chk(got, {11'h0, RATE_SEL_RST});
		$display("reset test done");
		// Register rows
		for (int i = 0; i < 6; i++)
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, got);
			chk(got, rows[i].e);
			step(4);
			if (rows[i].a == CLK_EN_ADDR)
				chk({7'h0, subsystem_clk_en_q}, rows[i].e);
		end
		// One subsystem clock at a time
		for (int b = 0; b < EN_W; b++)
		begin
			wr(CLK_EN_ADDR, 16'h0001 << b);
			step(6);
			acc = 9'h000;
			repeat (8)
			begin
				step();
				acc |= subsystem_mclk_q;
			end
			chk({7'h0, acc}, 16'h0001 << b);
		end
		$display("register test done");
		// Frame sources, neighbour first, then the selected one
		for (int c = 3; c < 32; c++)
		begin
			wr(RATE_SEL_ADDR, 16'(c));
			fire((c - 2) % 25, 16'h0000);
			fire((c - 3) % 25, {15'h0, c < 28});
		end
		$display("start source test done");
		// Input divider codes, quad interval scales with the ratio
		for (int d = 0; d < 6; d++)
		begin
			boot(3'(d), 2'h0, 8'h02);
			wr(RATE_SEL_ADDR, {11'h0, SEL_QUAD});
			meas(iv, tk);
			chk(16'(iv), 16'(div_exp[d]));
		end
		$display("divider test done");
		// Clock output modes
		for (int m = 0; m < 4; m++)
		begin
			boot(3'h2, 2'(m), 8'h02);
			chk({15'h0, clock_output_oe_q}, {15'h0, m != 0});
			step(64);  // Multipliers need whole reference periods first
			n = 0;
			prev = clock_output_pin_q;
			repeat (1600)
			begin
				step();
				n += int'(clock_output_pin_q === 1'b1 && prev === 1'b0);
				prev = clock_output_pin_q;
			end
			near(n, clk_exp[m]);
		end
		$display("clock output test done");
		// Core ticks per sample at normal, dual and quad rate
		boot(3'h0, 2'h0, 8'h20);
		for (int s = 0; s < 3; s++)
		begin
			wr(RATE_SEL_ADDR, 16'(s));
			meas(iv, tk);
			chk(16'(iv), 16'(4096 >> s));
			near(tk, 3584 >> s);
		end
		$display("core rate test done");
		stop_test();
	end
endmodule
